// file: core/fpiu_det_if.sv
`timescale 1ns/1ps
`default_nettype none
// Detector to sequencer: pending requests; sequencer to detector: latch clears
interface fpiu_det_if;
	logic [4:0] pend;
	logic [4:0] clr;
	modport det(output pend, input clr);
	modport seq(input pend, output clr);
endinterface
`default_nettype wire

// file: core/fpiu_detect.sv
`timescale 1ns/1ps
`default_nettype none
module fpiu_detect (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [4:0] line_sync,
	input wire logic src1_level_select,
	input wire logic src2_edge_polarity,
	fpiu_det_if.det dif
);
	import fpiu_pkg::*;
	logic [4:0] prev_r, prev_nxt;
	logic [2:0] latch_r, latch_nxt;
	logic fall0, fall1, edge2;
	always_comb begin
		prev_nxt = line_sync;
		fall0 = prev_r[0] & ~line_sync[0];
		fall1 = prev_r[1] & ~line_sync[1];
		edge2 = src2_edge_polarity ? (~prev_r[2] & line_sync[2]) :
			(prev_r[2] & ~line_sync[2]); // [RULE_10]
		latch_nxt = latch_r;
		// Clear first, so an edge in the clear cycle still sets
		if (dif.clr[0]) latch_nxt[0] = 1'b0; // [RULE_08]
		if (dif.clr[1]) latch_nxt[1] = 1'b0; // [RULE_12]
		if (dif.clr[2]) latch_nxt[2] = 1'b0; // [RULE_12]
		if (fall0) latch_nxt[0] = 1'b1; // [RULE_08]
		if (fall1 && !src1_level_select) latch_nxt[1] = 1'b1; // [RULE_09]
		if (src1_level_select) latch_nxt[1] = 1'b0;
		if (edge2) latch_nxt[2] = 1'b1; // [RULE_12]
		dif.pend[0] = latch_r[0];
		dif.pend[1] = src1_level_select ? ~line_sync[1] : latch_r[1]; // [RULE_09] [RULE_13]
		dif.pend[2] = latch_r[2];
		dif.pend[4:3] = ~line_sync[4:3]; // [RULE_11]
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			prev_r <= 5'h1f;
			latch_r <= 3'h0;
		end else begin
			prev_r <= prev_nxt;
			latch_r <= latch_nxt;
		end
	end
	a_edge_sets_latch: assert property (@(posedge clk) disable iff (!rstn)
		(src2_edge_polarity && !prev_r[2] && line_sync[2]) |=> latch_r[2]) // [RULE_10]
		else $error("rising edge did not set source 2 latch");
	a_level_no_store: assert property (@(posedge clk) disable iff (!rstn)
		dif.pend[4:3] == ~line_sync[4:3]) // [RULE_11]
		else $error("level source stored");
endmodule
`default_nettype wire

// file: core/fpiu_pkg.sv
// Summary of operation
// RULE_01: Four maskable sources plus one non-maskable source, each with its own vector.
// RULE_02: Vectors fixed: #0 FFCh, #1 FF6h, #2 FF4h, #3 FF2h, #4 FF0h.
// RULE_03: Accepted request loads the program counter with the selected vector address.
// RULE_04: Non-maskable preempts any routine; maskable sources never preempt each other.
// RULE_05: Pending maskable requests served in fixed order, #1 highest, #4 lowest.
// RULE_06: Several events may OR onto one source; each keeps a readable flag.
// RULE_07: Global enable clear blocks maskables and all wake-up, non-maskable still active.
// RULE_08: Non-maskable request held in a flip-flop cleared when its routine begins.
// RULE_09: Source #1 level-sensitive when level select set, else falling edge.
// RULE_10: Source #2 always edge; polarity bit set means rising, clear falling.
// RULE_11: Sources #3 and #4 detected by level only, nothing stored.
// RULE_12: Edge latch sets on edge, clears at routine start; only one pending kept.
// RULE_13: Level requester must hold line low when sampled at an instruction end.
// RULE_14: Requests tested at each instruction boundary; next instruction replaced by entry.
// RULE_15: Entry swaps carry and zero flags to interrupt or non-maskable pair.
// RULE_16: Entry pushes program counter, then inhibits maskables, non-maskable stays active.
// RULE_17: After masking, the source latch is cleared, then the vector loaded.
// RULE_18: Return restores previous flag pair and pops the saved program counter.
// RULE_19: Request during option register write must still swap flags; no defect.
// RULE_20: Option register is write-only with no single-bit operations.
// RULE_21: Reset clears the option register: maskables off, sources #1 and #2 falling edge.
// RULE_22: Maskable requests ignored while a maskable routine runs, served after return.
package fpiu_pkg;
	localparam int PC_W = 12;
	localparam int NSRC = 5;
	localparam logic [PC_W-1:0] VEC_SRC0 = 12'hffc;
	localparam logic [PC_W-1:0] VEC_SRC1 = 12'hff6;
	localparam logic [PC_W-1:0] VEC_SRC2 = 12'hff4;
	localparam logic [PC_W-1:0] VEC_SRC3 = 12'hff2;
	localparam logic [PC_W-1:0] VEC_SRC4 = 12'hff0;
	localparam logic [7:0] IOR_RESET = 8'h00;
	localparam int IOR_LES_BIT = 6;
	localparam int IOR_ESB_BIT = 5;
	localparam int IOR_GEN_BIT = 4;
	localparam logic [1:0] FLAGS_RESET = 2'h0;
	// Flag pair selector
	typedef enum logic [1:0] {FPIU_FS_NORMAL, FPIU_FS_IRQ, FPIU_FS_NMI} fpiu_fset_t;
endpackage

// file: core/fpiu_top.sv
`timescale 1ns/1ps
`default_nettype none
module fpiu_top #(
	parameter int EV_PER_SRC = 4
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [EV_PER_SRC*5-1:0] event_lines_n,
	input wire logic [EV_PER_SRC*5-1:0] event_flags_in,
	input wire logic instr_boundary,
	input wire logic [fpiu_pkg::PC_W-1:0] pc_next,
	input wire logic ior_wr,
	input wire logic [7:0] ior_wdata,
	input wire logic return_from_interrupt_op,
	input wire logic core_asleep,
	input wire logic carry_in,
	input wire logic zero_in,
	input wire logic flags_wr,
	output logic entry_take,
	output logic [fpiu_pkg::PC_W-1:0] pc_load,
	output logic pc_load_valid,
	output logic [fpiu_pkg::PC_W-1:0] stack_push_data,
	output logic stack_push,
	output logic stack_pop,
	output logic [2:0] active_src,
	output logic carry_flag,
	output logic zero_flag,
	output fpiu_pkg::fpiu_fset_t flag_set,
	output logic wake_req,
	output logic [EV_PER_SRC*5-1:0] event_flags
);
	import fpiu_pkg::*;
	typedef enum {FPIU_IDLE, FPIU_MASK, FPIU_VECTOR} fpiu_state_t;
	fpiu_det_if dif ();
	logic [4:0] ln_s1_r, ln_s2_r;
	logic [7:0] ior_r, ior_nxt;
	fpiu_state_t st_r, st_nxt;
	logic in_irq_r, in_irq_nxt, in_nmi_r, in_nmi_nxt;
	logic [2:0] src_r, src_nxt, sel;
	logic [PC_W-1:0] pc_r, pc_nxt, push_d_r, push_d_nxt;
	logic take_r, take_nxt, pcv_r, pcv_nxt, push_r, push_nxt, pop_r, pop_nxt;
	logic [1:0] fl_n_r, fl_i_r, fl_m_r, fl_n_nxt, fl_i_nxt, fl_m_nxt;
	fpiu_fset_t fs_r, fs_nxt, fs_prev_r, fs_prev_nxt;
	logic wake_r, wake_nxt;
	logic carry_r, carry_nxt, zero_r, zero_nxt;
	logic [EV_PER_SRC*5-1:0] evf_r;
	logic [4:0] clr;
	logic [4:0] combined;
	logic gen, mask_ok, any;
	logic [PC_W-1:0] vec;
	genvar g;
	generate
		for (g = 0; g < 5; g++) begin : g_or
			// Any low event pulls the source line low
			assign combined[g] = &event_lines_n[g*EV_PER_SRC +: EV_PER_SRC]; // [RULE_06]
		end
	endgenerate
	fpiu_detect u_det (
		.clk(clk),
		.rstn(rstn),
		.line_sync(ln_s2_r),
		.src1_level_select(ior_r[IOR_LES_BIT]),
		.src2_edge_polarity(ior_r[IOR_ESB_BIT]),
		.dif(dif)
	);
	assign dif.clr = clr;
	assign gen = ior_r[IOR_GEN_BIT];
	assign mask_ok = gen && !in_irq_r && !in_nmi_r; // [RULE_07] [RULE_22]
	always_comb begin
		sel = 3'd0;
		any = 1'b0;
		vec = VEC_SRC0;
		// NMI first, then maskables in fixed order
		if (dif.pend[0] && !in_nmi_r) begin // [RULE_04]
			any = 1'b1;
		end else if (mask_ok && dif.pend[1]) begin // [RULE_05]
			sel = 3'd1;
			any = 1'b1;
			vec = VEC_SRC1;
		end else if (mask_ok && dif.pend[2]) begin
			sel = 3'd2;
			any = 1'b1;
			vec = VEC_SRC2;
		end else if (mask_ok && dif.pend[3]) begin
			sel = 3'd3;
			any = 1'b1;
			vec = VEC_SRC3;
		end else if (mask_ok && dif.pend[4]) begin
			sel = 3'd4;
			any = 1'b1;
			vec = VEC_SRC4;
		end // [RULE_01] [RULE_02]
	end
	always_comb begin
		ior_nxt = ior_wr ? ior_wdata : ior_r; // [RULE_20]
		st_nxt = st_r;
		in_irq_nxt = in_irq_r;
		in_nmi_nxt = in_nmi_r;
		src_nxt = src_r;
		pc_nxt = pc_r;
		push_d_nxt = push_d_r;
		take_nxt = 1'b0;
		pcv_nxt = 1'b0;
		push_nxt = 1'b0;
		pop_nxt = 1'b0;
		fl_n_nxt = fl_n_r;
		fl_i_nxt = fl_i_r;
		fl_m_nxt = fl_m_r;
		fs_nxt = fs_r;
		fs_prev_nxt = fs_prev_r;
		clr = 5'h0;
		// Flag writes go to whichever pair is live
		if (flags_wr) begin
			case (fs_r)
				FPIU_FS_NORMAL: fl_n_nxt = {carry_in, zero_in};
				FPIU_FS_IRQ: fl_i_nxt = {carry_in, zero_in};
				FPIU_FS_NMI: fl_m_nxt = {carry_in, zero_in};
				default: fl_n_nxt = fl_n_r;
			endcase
		end
		// Wake only with global enable, even for NMI
		wake_nxt = core_asleep && gen && (dif.pend[0] || (|dif.pend[4:1])); // [RULE_07]
		case (st_r)
			FPIU_IDLE: begin
				if (instr_boundary && any) begin // [RULE_14]
					take_nxt = 1'b1;
					src_nxt = sel;
					pc_nxt = vec;
					// Swap is atomic with acceptance, regardless of any option write
					fs_prev_nxt = fs_r; // [RULE_19]
					fs_nxt = (sel == 3'd0) ? FPIU_FS_NMI : FPIU_FS_IRQ; // [RULE_15]
					push_d_nxt = pc_next;
					push_nxt = 1'b1; // [RULE_16]
					st_nxt = FPIU_MASK;
				end else if (return_from_interrupt_op && (in_irq_r || in_nmi_r)) begin
					pop_nxt = 1'b1; // [RULE_18]
					fs_nxt = fs_prev_r;
					if (in_nmi_r) in_nmi_nxt = 1'b0;
					else in_irq_nxt = 1'b0;
					fs_prev_nxt = FPIU_FS_NORMAL;
				end
			end
			FPIU_MASK: begin
				if (src_r == 3'd0) in_nmi_nxt = 1'b1;
				else in_irq_nxt = 1'b1; // [RULE_16]
				st_nxt = FPIU_VECTOR;
			end
			FPIU_VECTOR: begin
				clr[src_r] = 1'b1; // [RULE_17] [RULE_08]
				pcv_nxt = 1'b1; // [RULE_03]
				st_nxt = FPIU_IDLE;
			end
			default: st_nxt = FPIU_IDLE;
		endcase
		// Live pair registered so the flag outputs come from flip-flops
		case (fs_nxt)
			FPIU_FS_NMI: {carry_nxt, zero_nxt} = fl_m_nxt;
			FPIU_FS_IRQ: {carry_nxt, zero_nxt} = fl_i_nxt;
			default: {carry_nxt, zero_nxt} = fl_n_nxt;
		endcase
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ln_s1_r <= 5'h1f;
			ln_s2_r <= 5'h1f;
			evf_r <= '0;
			ior_r <= IOR_RESET; // [RULE_21]
			st_r <= FPIU_IDLE;
			in_irq_r <= 1'b0;
			in_nmi_r <= 1'b0;
			src_r <= 3'd0;
			pc_r <= '0;
			push_d_r <= '0;
			take_r <= 1'b0;
			pcv_r <= 1'b0;
			push_r <= 1'b0;
			pop_r <= 1'b0;
			fl_n_r <= FLAGS_RESET;
			fl_i_r <= FLAGS_RESET;
			fl_m_r <= FLAGS_RESET;
			fs_r <= FPIU_FS_NORMAL;
			fs_prev_r <= FPIU_FS_NORMAL;
			wake_r <= 1'b0;
			carry_r <= FLAGS_RESET[1];
			zero_r <= FLAGS_RESET[0];
		end else begin
			ln_s1_r <= combined;
			ln_s2_r <= ln_s1_r;
			evf_r <= event_flags_in; // [RULE_06]
			ior_r <= ior_nxt;
			st_r <= st_nxt;
			in_irq_r <= in_irq_nxt;
			in_nmi_r <= in_nmi_nxt;
			src_r <= src_nxt;
			pc_r <= pc_nxt;
			push_d_r <= push_d_nxt;
			take_r <= take_nxt;
			pcv_r <= pcv_nxt;
			push_r <= push_nxt;
			pop_r <= pop_nxt;
			fl_n_r <= fl_n_nxt;
			fl_i_r <= fl_i_nxt;
			fl_m_r <= fl_m_nxt;
			fs_r <= fs_nxt;
			fs_prev_r <= fs_prev_nxt;
			wake_r <= wake_nxt;
			carry_r <= carry_nxt;
			zero_r <= zero_nxt;
		end
	end
	assign entry_take = take_r;
	assign pc_load = pc_r;
	assign pc_load_valid = pcv_r;
	assign stack_push_data = push_d_r;
	assign stack_push = push_r;
	assign stack_pop = pop_r;
	assign active_src = src_r;
	assign flag_set = fs_r;
	assign carry_flag = carry_r; // [RULE_15]
	assign zero_flag = zero_r;
	assign wake_req = wake_r;
	assign event_flags = evf_r;
	a_vec_two_later: assert property (@(posedge clk) disable iff (!rstn)
		entry_take |-> ##2 (pc_load_valid && pc_load == $past(pc_load, 2))) // [RULE_03]
		else $error("vector not loaded two cycles after entry");
	a_push_with_take: assert property (@(posedge clk) disable iff (!rstn)
		entry_take |-> stack_push) // [RULE_16]
		else $error("entry without push");
	a_swap_on_take: assert property (@(posedge clk) disable iff (!rstn)
		entry_take |-> flag_set != FPIU_FS_NORMAL) // [RULE_15] [RULE_19]
		else $error("flags not swapped on entry");
	a_no_mask_nest: assert property (@(posedge clk) disable iff (!rstn)
		(entry_take && in_irq_r) |-> active_src == 3'd0) // [RULE_04]
		else $error("maskable nested in maskable");
	a_gen_blocks: assert property (@(posedge clk) disable iff (!rstn)
		(entry_take && $past(!gen)) |-> active_src == 3'd0) // [RULE_07]
		else $error("maskable taken with global enable off");
	a_prio_order: assert property (@(posedge clk) disable iff (!rstn)
		(st_r == FPIU_IDLE && instr_boundary && mask_ok && dif.pend[1] && !dif.pend[0])
		|=> active_src == 3'd1) // [RULE_05]
		else $error("source 1 not served first");
	a_return_from_interrupt_op_pops: assert property (@(posedge clk) disable iff (!rstn)
		(st_r == FPIU_IDLE && !(instr_boundary && any) && return_from_interrupt_op
		&& in_irq_r && !in_nmi_r) |=> (stack_pop && flag_set == FPIU_FS_NORMAL)) // [RULE_18]
		else $error("return did not pop and restore");
	a_ior_reset: assert property (@(posedge clk) disable iff (!rstn)
		$rose(rstn) |-> ior_r == IOR_RESET) // [RULE_21]
		else $error("option register not cleared");
	c_nmi_entry: cover property (@(posedge clk) disable iff (!rstn)
		entry_take && active_src == 3'd0);
	c_mask_entry: cover property (@(posedge clk) disable iff (!rstn)
		entry_take && active_src == 3'd4);
	c_nmi_preempt: cover property (@(posedge clk) disable iff (!rstn)
		entry_take && in_irq_r);
	c_return: cover property (@(posedge clk) disable iff (!rstn) stack_pop);
endmodule
`default_nettype wire

// file: verif/fixed_priority_interrupt_unit_test.sv
`timescale 1ns/1ps
`default_nettype none
module fixed_priority_interrupt_unit_test;
	import fpiu_pkg::*;
	logic clk = 0, rstn = 0, ib, ior_wr = 0, ret_op = 0, asleep = 0;
	logic carry_in = 0, zero_in = 0, flags_wr = 0, entry_take, pc_load_valid, stack_push;
	logic stack_pop, carry_flag, zero_flag, wake_req;
	logic [19:0] lines = 20'hfffff, ev_in = 20'h0, ev_out;
	logic [7:0] ior_wdata = 8'h00;
	logic [11:0] pc_next, pc_load, push_data;
	logic [2:0] active_src;
	fpiu_fset_t flag_set;
	logic [11:0] vecs [5] = '{VEC_SRC0, VEC_SRC1, VEC_SRC2, VEC_SRC3, VEC_SRC4};
	int miscompares = 0, compares = 0;
	always #20 clk = ~clk;
	fpiu_core_model core (.clk(clk), .rstn(rstn), .run(!asleep), .instr_boundary(ib),
		.pc_next(pc_next));
	fpiu_top #(.EV_PER_SRC(4)) DUT (.clk(clk), .rstn(rstn), .event_lines_n(lines),
		.event_flags_in(ev_in), .instr_boundary(ib), .pc_next(pc_next), .ior_wr(ior_wr),
		.ior_wdata(ior_wdata), .return_from_interrupt_op(ret_op), .core_asleep(asleep),
		.carry_in(carry_in), .zero_in(zero_in), .flags_wr(flags_wr), .entry_take(entry_take),
		.pc_load(pc_load), .pc_load_valid(pc_load_valid), .stack_push_data(push_data),
		.stack_push(stack_push), .stack_pop(stack_pop), .active_src(active_src),
		.carry_flag(carry_flag), .zero_flag(zero_flag), .flag_set(flag_set),
		.wake_req(wake_req), .event_flags(ev_out));
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task close_out;
		$display("Counts: %0d compares, %0d miscompares", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task wr_ior(input logic [7:0] v);
		@(posedge clk) ior_wr <= 1;
		ior_wdata <= v;
		@(posedge clk) ior_wr <= 0;
	endtask
	task quiet(input int n);
		logic seen;
		seen = 0;
		repeat (n) begin
			@(posedge clk);
			#1 seen |= entry_take;
		end
		chk(seen, 0);
	endtask
	// Waits a bounded time for the vector load, then judges it
	task take(input int s, input fpiu_fset_t fs);
		logic pu;
		pu = 0;
		for (int i = 0; i < 40; i++) begin
			@(posedge clk);
			#1;
			pu |= (stack_push === 1'b1);
			if (pc_load_valid === 1'b1)
				break;
		end
		chk(pu, 1);
		chk(pc_load_valid, 1);
		chk(pc_load, vecs[s]);
		chk(active_src, s);
		chk(flag_set, fs);
	endtask
	task ret(input fpiu_fset_t fs);
		logic p;
		quiet(12);
		@(posedge clk) ret_op <= 1;
		@(posedge clk) ret_op <= 0;
		#1 p = stack_pop;
		@(posedge clk);
		#1 p |= stack_pop;
		chk(p, 1);
		chk(flag_set, fs);
	endtask
	task t_reset_nmi;
		chk(flag_set, FPIU_FS_NORMAL);
		@(posedge clk) lines[12] <= 0;
		quiet(20);
		lines[12] <= 1;
		asleep <= 1;
		lines[0] <= 0;
		repeat (8) @(posedge clk);
		#1 chk(wake_req, 0);
		asleep <= 0;
		take(0, FPIU_FS_NMI);
		lines[0] <= 1;
		ret(FPIU_FS_NORMAL);
	endtask
	// All four maskables at once, served one routine at a time
	task t_order;
		@(posedge clk) flags_wr <= 1;
		carry_in <= 1;
		zero_in <= 1;
		@(posedge clk) flags_wr <= 0;
		wr_ior(8'h10);
		@(posedge clk) asleep <= 1;
		lines <= 20'heeeef;
		repeat (8) @(posedge clk);
		#1 chk(wake_req, 1);
		asleep <= 0;
		for (int s = 1; s < 5; s++) begin
			take(s, FPIU_FS_IRQ);
			if (s == 1)
				chk({carry_flag, zero_flag}, 2'h0);
			lines[s*4] <= 1;
			ret(FPIU_FS_NORMAL);
			if (s == 1)
				chk({carry_flag, zero_flag}, 2'h3);
		end
	endtask
	task t_preempt;
		@(posedge clk) lines[16] <= 0;
		take(4, FPIU_FS_IRQ);
		lines[0] <= 0;
		take(0, FPIU_FS_NMI);
		lines[0] <= 1;
		lines[16] <= 1;
		ret(FPIU_FS_IRQ);
		ret(FPIU_FS_NORMAL);
	endtask
	task t_modes;
		wr_ior(8'h50);
		@(posedge clk) lines[4] <= 0;
		take(1, FPIU_FS_IRQ);
		ret(FPIU_FS_NORMAL);
		take(1, FPIU_FS_IRQ);
		lines[4] <= 1;
		ret(FPIU_FS_NORMAL);
		wr_ior(8'h30);
		@(posedge clk) lines[8] <= 0;
		quiet(16);
		lines[8] <= 1;
		take(2, FPIU_FS_IRQ);
		ret(FPIU_FS_NORMAL);
		quiet(16);
	endtask
	task t_flags;
		@(posedge clk) ev_in <= 20'h5a3c1;
		@(posedge clk);
		#1 chk(ev_out, 20'h5a3c1);
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rstn <= 1;
		repeat (3) @(posedge clk);
		t_reset_nmi();
		t_order();
		t_preempt();
		t_modes();
		t_flags();
		close_out();
	end
	// Whole run needs a few hundred cycles; the limit allows 10000
	initial begin
		#400us;
		miscompares++;
		close_out();
	end
endmodule
`default_nettype wire

// file: verif/fpiu_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module fpiu_core_model (
	input wire logic clk,
	input wire logic rstn,
	input wire logic run,
	output logic instr_boundary,
	output logic [fpiu_pkg::PC_W-1:0] pc_next
);
	logic [1:0] cnt_r;
	// Four-cycle instructions; a sleeping core runs none
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_r <= 2'h0;
			pc_next <= 12'h100;
		end else if (run) begin
			cnt_r <= cnt_r + 2'h1;
			if (cnt_r == 2'h3)
				pc_next <= pc_next + 12'h001;
		end
	end
	assign instr_boundary = run && (cnt_r == 2'h3);
endmodule
`default_nettype wire
